/* File: core/ost_timer.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// How it works
// - resets, stop, osc stop/cut clear status
// - status read-only, bit or byte reads
// - bits 7..5 zero, flags 2^11..2^16 below
// - flags set in order and stay set
// - after stop release count only to selection
// - wait counted from first oscillator edge
// - wait select written by byte only
// - reset input loads wait select 05H
// - codes 1..5 map to 2^11..2^16 waits
// - cpu held only when high-speed clock runs cpu
// - osc stop bit halts the oscillator
module ost_timer
    import ost_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        nrst_in,
    input  wire logic        osc_clk_in,
    input  wire logic [15:0] addr_in,
    input  wire logic        rd_en_in,
    input  wire logic        wr_en_in,
    input  wire logic        bit_op_in,
    input  wire logic [2:0]  bit_idx_in,
    input  wire logic [7:0]  wr_data_in,
    input  wire logic        reset_event_in,
    input  wire logic        stop_exec_in,
    input  wire logic        stop_release_in,
    input  wire logic        cpu_clk_hs_in,
    input  wire logic        main_osc_stop_in,
    input  wire logic        main_osc_cut_in,
    output logic [7:0]       rd_data_out,
    output logic             rd_bit_out,
    output logic             osc_enable_out,
    output logic             cpu_clk_hold_out
);
    ////////////////////////////////////////////////////////////////////////////
    logic                 osc_rise;
    ost_state_e           state_reg;
    ost_state_e           state_next;
    logic [OST_CNT_W-1:0] cnt_reg;
    logic [OST_CNT_W-1:0] cnt_next;
    logic [OST_CNT_W-1:0] limit_reg;
    logic [OST_CNT_W-1:0] limit_next;
    logic [OST_NUM_FLAGS-1:0] flag_reg;
    logic [OST_NUM_FLAGS-1:0] flag_next;
    logic [OST_SEL_W-1:0] sel_reg;
    logic [OST_SEL_W-1:0] sel_next;
    logic [7:0]           rd_data_reg;
    logic [7:0]           rd_data_next;
    logic                 rd_bit_reg;
    logic                 rd_bit_next;
    logic                 clear_evt;
    logic [7:0]           status_val;
    logic [7:0]           sel_val;
    logic [7:0]           rd_val;
    // decoded state and register port strobes
    logic                 osc_halt;
    logic                 in_stop;
    logic                 in_wait;
    logic                 cnt_at_limit;
    logic                 cnt_step;
    logic                 hit_status;
    logic                 hit_sel;
    logic                 sel_wr;
    logic [OST_NUM_FLAGS-1:0] flag_rev;

    // oscillator pin is asynchronous to clk_in
    ost_osc_sync u_sync (
        .clk_in   (clk_in),
        .nrst_in  (nrst_in),
        .osc_in   (osc_clk_in),
        .rise_out (osc_rise)
    );

    ////////////////////////////////////////////////////////////////////////////
    // counter and stop sequencing
    assign osc_halt     = main_osc_stop_in | main_osc_cut_in;
    assign clear_evt    = reset_event_in | stop_exec_in | osc_halt;
    assign in_stop      = (state_reg == OST_ST_STOP);
    assign in_wait      = (state_reg == OST_ST_WAIT);
    // saturate at the limit instead of wrapping back to zero
    assign cnt_at_limit = (cnt_reg >= limit_reg);
    // counting rides on real oscillator edges only, so the start-up gap is excluded
    assign cnt_step     = osc_rise & ~in_stop & ~cnt_at_limit;

    always_comb begin
        state_next = state_reg;
        limit_next = limit_reg;
        cnt_next   = cnt_reg;
        case (state_reg)
            OST_ST_RUN: begin
                if (stop_exec_in) begin
                    state_next = OST_ST_STOP;
                end
            end
            OST_ST_STOP: begin
                if (stop_release_in) begin
                    // limit stays until a reset or the next release, so a later restart also stops there
                    limit_next = ost_sel_limit(sel_reg);
                    state_next = cpu_clk_hs_in ? OST_ST_WAIT : OST_ST_RUN;
                end
            end
            OST_ST_WAIT: begin
                // hold drops on the edge after the count meets the selected wait
                if (cnt_at_limit) begin
                    state_next = OST_ST_RUN;
                end
            end
            default: begin
                state_next = OST_ST_RUN;
            end
        endcase
        if (reset_event_in) begin
            state_next = OST_ST_RUN;
            limit_next = OST_CNT_FULL;
        end
        if (clear_evt) begin
            cnt_next = OST_CNT_ZERO;
        end else if (cnt_step) begin
            cnt_next = cnt_reg + OST_CNT_ONE;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            state_reg <= OST_ST_RUN;
            cnt_reg   <= OST_CNT_ZERO;
            limit_reg <= OST_CNT_FULL;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            limit_reg <= limit_next;
        end
    end

    // oscillator halted by the stop bit, the cut bit or stop mode
    // left combinational so the oscillator stops in the cycle the bit is set
    assign osc_enable_out   = ~(osc_halt | in_stop);
    assign cpu_clk_hold_out = in_wait;

    ////////////////////////////////////////////////////////////////////////////
    // thermometer flags
    genvar gi;
    generate
        for (gi = 0; gi < OST_NUM_FLAGS; gi++) begin : g_flag
            always_comb begin
                if (clear_evt) begin
                    flag_next[gi] = 1'b0;
                end else begin
                    // counter never passes the limit, so higher flags stay clear
                    flag_next[gi] = flag_reg[gi] | (cnt_reg >= ost_thresh(gi));
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            flag_reg <= OST_STATUS_RESET[OST_NUM_FLAGS-1:0];
        end else begin
            flag_reg <= flag_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register port
    // index 0 (2^11) lands in bit 4, index 4 (2^16) in bit 0
    genvar bi;
    generate
        for (bi = 0; bi < OST_NUM_FLAGS; bi++) begin : g_stat
            assign flag_rev[OST_NUM_FLAGS-1-bi] = flag_reg[bi];
        end
    endgenerate
    assign status_val = {3'h0, flag_rev};
    assign sel_val    = {5'h00, sel_reg};

    assign hit_status = (addr_in == OST_ADDR_STATUS);
    assign hit_sel    = (addr_in == OST_ADDR_WAIT_SEL);
    // bit writes are dropped, status ignores all writes
    assign sel_wr     = wr_en_in & ~bit_op_in & hit_sel;

    always_comb begin
        sel_next     = sel_reg;
        rd_data_next = rd_data_reg;
        rd_bit_next  = rd_bit_reg;
        rd_val       = OST_DATA_ZERO;
        if (hit_status) begin
            rd_val = status_val;
        end else if (hit_sel) begin
            rd_val = sel_val;
        end
        if (rd_en_in) begin
            rd_data_next = rd_val;
            rd_bit_next  = rd_val[bit_idx_in];
        end
        if (sel_wr) begin
            sel_next = wr_data_in[OST_SEL_W-1:0];
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            sel_reg     <= OST_WAIT_SEL_RESET[OST_SEL_W-1:0];
            rd_data_reg <= OST_DATA_ZERO;
            rd_bit_reg  <= 1'b0;
        end else begin
            sel_reg     <= sel_next;
            rd_data_reg <= rd_data_next;
            rd_bit_reg  <= rd_bit_next;
        end
    end

    assign rd_data_out = rd_data_reg;
    assign rd_bit_out  = rd_bit_reg;
endmodule

/* File: core/ost_pkg.sv */
package ost_pkg;
    // register map, byte addresses on the cpu data bus
    localparam logic [15:0] OST_ADDR_STATUS   = 16'hFFA3;
    localparam logic [15:0] OST_ADDR_WAIT_SEL = 16'hFFA4;
    localparam logic [7:0]  OST_STATUS_RESET  = 8'h00;
    localparam logic [7:0]  OST_WAIT_SEL_RESET = 8'h05;
    localparam logic [7:0]  OST_DATA_ZERO     = 8'h00;
    // wait select field sits in bits 2..0
    localparam int          OST_SEL_W         = 3;
    localparam int          OST_NUM_FLAGS     = 5;
    // counter reaches 2^16 and saturates there
    localparam int          OST_CNT_W         = 17;
    localparam logic [16:0] OST_CNT_ZERO      = 17'h00000;
    localparam logic [16:0] OST_CNT_ONE       = 17'h00001;
    localparam logic [16:0] OST_CNT_FULL      = 17'h10000;

    // flag index 0 is the 2^11 flag (status bit 4), index 4 the 2^16 flag (bit 0)
    function automatic logic [16:0] ost_thresh(input int idx);
        case (idx)
            0:       ost_thresh = 17'h00800;
            1:       ost_thresh = 17'h02000;
            2:       ost_thresh = 17'h04000;
            3:       ost_thresh = 17'h08000;
            default: ost_thresh = 17'h10000;
        endcase
    endfunction

    // codes 001..101 select 2^11..2^16; forbidden codes fall back to the longest wait
    function automatic logic [16:0] ost_sel_limit(input logic [2:0] code);
        case (code)
            3'h1:    ost_sel_limit = 17'h00800;
            3'h2:    ost_sel_limit = 17'h02000;
            3'h3:    ost_sel_limit = 17'h04000;
            3'h4:    ost_sel_limit = 17'h08000;
            default: ost_sel_limit = 17'h10000;
        endcase
    endfunction

    typedef enum logic [1:0] {
        OST_ST_RUN  = 2'b00,
        OST_ST_STOP = 2'b01,
        OST_ST_WAIT = 2'b10
    } ost_state_e;
endpackage

/* File: core/ost_osc_sync.sv */
`timescale 1ns/1ps
module ost_osc_sync (
    input  wire logic clk_in,
    input  wire logic nrst_in,
    input  wire logic osc_in,
    output logic      rise_out
);
    logic [2:0] sh_reg;
    logic [2:0] sh_next;

    // sh_reg[0] feeds only sh_reg[1]; the edge is taken from the later stages
    always_comb begin
        sh_next = {sh_reg[1:0], osc_in};
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            sh_reg <= 3'h0;
        end else begin
            sh_reg <= sh_next;
        end
    end

    assign rise_out = sh_reg[1] & ~sh_reg[2];
endmodule

/* File: verification/ost_osc_model.sv */
`timescale 1ns/1ps
module ost_osc_model #(parameter int HALF_NS = 100) (
    input  wire logic en_in,
    output logic      osc_out
);
    initial osc_out = 1'b0;
    // halted oscillator rests low, restart begins a fresh cycle
    always begin
        if (en_in) begin
            #HALF_NS osc_out = 1'b1;
            #HALF_NS osc_out = 1'b0;
        end else begin
            @(posedge en_in);
        end
    end
endmodule

/* File: verification/ost_timer_asserts.sv */
`timescale 1ns/1ps
module ost_timer_asserts
    import ost_pkg::*;
(
    input wire logic        clk_in,
    input wire logic        nrst_in,
    input wire logic        osc_clk_in,
    input wire logic [15:0] addr_in,
    input wire logic        rd_en_in,
    input wire logic        wr_en_in,
    input wire logic        bit_op_in,
    input wire logic [2:0]  bit_idx_in,
    input wire logic [7:0]  wr_data_in,
    input wire logic        reset_event_in,
    input wire logic        stop_exec_in,
    input wire logic        stop_release_in,
    input wire logic        cpu_clk_hs_in,
    input wire logic        main_osc_stop_in,
    input wire logic        main_osc_cut_in,
    input wire logic [7:0]  rd_data_out,
    input wire logic        rd_bit_out,
    input wire logic        osc_enable_out,
    input wire logic        cpu_clk_hold_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    logic [15:0] hold_cnt_reg;
    logic [15:0] hold_cnt_next;
    always_comb hold_cnt_next = cpu_clk_hold_out ? hold_cnt_reg + 16'h0001 : 16'h0000;
    always_ff @(posedge clk_in) hold_cnt_reg <= hold_cnt_next;
    sequence s_stat_rd;
        rd_en_in && addr_in == OST_ADDR_STATUS;
    endsequence
    sequence s_osc_off;
        main_osc_stop_in || main_osc_cut_in;
    endsequence
    AST_UPPER_ZERO: assert property (rd_data_out[7:5] == 3'h0) else $error("status top bits set");
    AST_THERMO: assert property (s_stat_rd |=> rd_data_out inside {8'h00, 8'h10, 8'h18, 8'h1C, 8'h1E, 8'h1F})
        else $error("flags not in order");
    AST_BIT_RD: assert property (s_stat_rd |=> rd_bit_out == rd_data_out[$past(bit_idx_in)])
        else $error("bit read mismatch");
    AST_OFF_CLR: assert property (s_osc_off ##1 s_osc_off ##0 s_stat_rd |=> rd_data_out == OST_DATA_ZERO)
        else $error("status not cleared");
    AST_OSC_OFF: assert property (s_osc_off |-> !osc_enable_out) else $error("osc runs while stopped");
    AST_STOP_OSC: assert property (stop_exec_in && !stop_release_in |=> !osc_enable_out)
        else $error("osc runs in stop");
    AST_HOLD_CAUSE: assert property ($rose(cpu_clk_hold_out) |-> $past(stop_release_in) && $past(cpu_clk_hs_in))
        else $error("hold without release");
    AST_NO_HOLD_IS: assert property (stop_release_in && !cpu_clk_hs_in && !cpu_clk_hold_out |=> !cpu_clk_hold_out)
        else $error("hold on slow clock");
    AST_HOLD_OSC: assert property (cpu_clk_hold_out && !(main_osc_stop_in || main_osc_cut_in) |-> osc_enable_out)
        else $error("hold with osc off");
    // osc no faster than clk/2, so 2^11 edges take at least 4096 cycles
    AST_HOLD_LEN: assert property ($fell(cpu_clk_hold_out) && !$past(reset_event_in) |-> hold_cnt_reg >= 16'h1000)
        else $error("hold too short");
    AST_SEL_UPPER: assert property (rd_en_in && addr_in == OST_ADDR_WAIT_SEL |=> rd_data_out[7:3] == 5'h00)
        else $error("select top bits set");
endmodule

/* File: verification/ost_timer_tb_top.sv */
`timescale 1ns/1ps
module ost_timer_tb_top
    import ost_pkg::*;
;
    logic clk_in, nrst_in, osc_clk_in, rd_en_in, wr_en_in, bit_op_in, reset_event_in, stop_exec_in;
    logic stop_release_in, cpu_clk_hs_in, main_osc_stop_in, main_osc_cut_in, rd_bit_out, osc_enable_out;
    logic cpu_clk_hold_out;
    logic [15:0] addr_in;
    logic [2:0]  bit_idx_in;
    logic [7:0]  wr_data_in, rd_data_out;
    int n_fail = 0;
    int comparisons = 0;
    ost_timer dut (.clk_in, .nrst_in, .osc_clk_in, .addr_in, .rd_en_in, .wr_en_in, .bit_op_in, .bit_idx_in,
        .wr_data_in, .reset_event_in, .stop_exec_in, .stop_release_in, .cpu_clk_hs_in, .main_osc_stop_in,
        .main_osc_cut_in, .rd_data_out, .rd_bit_out, .osc_enable_out, .cpu_clk_hold_out);
    ost_osc_model osc (.en_in(osc_enable_out), .osc_out(osc_clk_in));
    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end
    ////////////////////////////////////////
    task automatic test_done;
        $display("errors %0d comparisons %0d", n_fail, comparisons);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // reads use d[2:0] as the bit number
    task automatic acc(input logic [15:0] a, input logic rd, input logic bop, input logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        rd_en_in <= rd;
        wr_en_in <= !rd;
        bit_op_in <= bop;
        wr_data_in <= d;
        bit_idx_in <= d[2:0];
        @(posedge clk_in);
        rd_en_in <= 1'b0;
        wr_en_in <= 1'b0;
        // read data launched on the last edge is settled by this one
        @(posedge clk_in);
    endtask
    task automatic t_regs;
        acc(OST_ADDR_STATUS, 1'b1, 1'b1, 8'h04);
        chk(rd_data_out, OST_STATUS_RESET);
        acc(OST_ADDR_WAIT_SEL, 1'b0, 1'b1, 8'h01);
        acc(OST_ADDR_WAIT_SEL, 1'b1, 1'b0, 8'h00);
        chk(rd_data_out, OST_WAIT_SEL_RESET);
        for (int c = 5; c >= 1; c--) begin
            acc(OST_ADDR_WAIT_SEL, 1'b0, 1'b0, 8'hF8 | 8'(c));
            acc(OST_ADDR_WAIT_SEL, 1'b1, 1'b0, 8'h00);
            chk(rd_data_out, 8'(c));
        end
        acc(OST_ADDR_STATUS, 1'b0, 1'b0, 8'hFF);
        acc(16'hFFA5, 1'b1, 1'b0, 8'h00);
        chk(rd_data_out, 8'h00);
        acc(OST_ADDR_STATUS, 1'b1, 1'b0, 8'h00);
        chk(rd_data_out, 8'h00);
    endtask
    // wait select is code 1 here; a long wait shows the count stays capped
    task automatic t_stop(input logic hs, input int n);
        if (hs) begin
            acc(OST_ADDR_STATUS, 1'b1, 1'b1, 8'h04);
            chk(rd_data_out, 8'h10);
            chk({7'h00, rd_bit_out}, 8'h01);
            acc(OST_ADDR_WAIT_SEL, 1'b0, 1'b0, 8'h01);
        end
        @(posedge clk_in);
        stop_exec_in <= 1'b1;
        cpu_clk_hs_in <= hs;
        @(posedge clk_in);
        stop_exec_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        #1;
        chk({7'h00, osc_enable_out}, 8'h00);
        acc(OST_ADDR_STATUS, 1'b1, 1'b0, 8'h00);
        chk(rd_data_out, 8'h00);
        stop_release_in <= 1'b1;
        @(posedge clk_in);
        stop_release_in <= 1'b0;
        #1;
        chk({7'h00, cpu_clk_hold_out}, {7'h00, hs});
        repeat (n) @(posedge clk_in);
        acc(OST_ADDR_STATUS, 1'b1, 1'b0, 8'h00);
        chk({rd_data_out[7:1], cpu_clk_hold_out}, 8'h10);
    endtask
    task automatic t_clear;
        for (int i = 1; i <= 2; i++) begin
            {main_osc_cut_in, main_osc_stop_in} <= 2'(i);
            repeat (2) @(posedge clk_in);
            acc(OST_ADDR_STATUS, 1'b1, 1'b0, 8'h00);
            chk({rd_data_out[7:1], osc_enable_out}, 8'h00);
        end
        {main_osc_cut_in, main_osc_stop_in} <= 2'h0;
        repeat (9000) @(posedge clk_in);
        acc(OST_ADDR_STATUS, 1'b1, 1'b0, 8'h00);
        chk(rd_data_out, 8'h10);
        reset_event_in <= 1'b1;
        @(posedge clk_in);
        reset_event_in <= 1'b0;
        acc(OST_ADDR_STATUS, 1'b1, 1'b0, 8'h00);
        chk(rd_data_out, 8'h00);
        nrst_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        nrst_in <= 1'b1;
        acc(OST_ADDR_WAIT_SEL, 1'b1, 1'b0, 8'h00);
        chk(rd_data_out, 8'h05);
    endtask
    initial begin
        {nrst_in, rd_en_in, wr_en_in, bit_op_in, reset_event_in, stop_exec_in, stop_release_in} = 7'h00;
        {cpu_clk_hs_in, main_osc_stop_in, main_osc_cut_in, addr_in, bit_idx_in, wr_data_in} = 30'h0;
        repeat (3) @(posedge clk_in);
        nrst_in <= 1'b1;
        t_regs;
        t_stop(1'b0, 36000);
        t_stop(1'b1, 10000);
        t_clear;
        test_done;
    end
    initial begin
        repeat (80000) @(posedge clk_in);
        n_fail++;
        test_done;
    end
endmodule
bind ost_timer ost_timer_asserts u_chk (.clk_in, .nrst_in, .osc_clk_in, .addr_in, .rd_en_in, .wr_en_in,
    .bit_op_in, .bit_idx_in, .wr_data_in, .reset_event_in, .stop_exec_in, .stop_release_in, .cpu_clk_hs_in,
    .main_osc_stop_in, .main_osc_cut_in, .rd_data_out, .rd_bit_out, .osc_enable_out, .cpu_clk_hold_out);
